/* File: src/otp_params.svh */
// constants for the motor 3/4 over-torque and thermal protection block
// Summary of operation
// - faults are stored as numeric codes
// - record only faults that stop the drive
// - skip undervolt at stop, record running ones
// - backup event writes code 62 to both sets
// - over-torque mode 0 off, 1-4 continue/stop
// - modes 1,3 warn and keep running, no record
// - modes 2,4 stop drive and record fault
// - declare after current over level beyond time
// - level 10 to 250 percent, reset 120
// - warning holds until current below 5 percent
// - after over-torque stop, run needs manual reset
// - thermal mode 0 external, 1 standard, 2 off
// - thermal action time resets to 60.0 s
// - thermal threshold is 150 percent full load
// - accumulate time above threshold, trip past limit
// - thermal trip reports code and coasts motor
// - higher current trips sooner, lower later
// - standard motor trips sooner at low speed
// - external cooling ignores low speed
// - power off clears thermal accumulation
`ifndef OTP_PARAMS_SVH
`define OTP_PARAMS_SVH

// register indices; byte address is index times four
`define OTP_IX_OT_SEL_M3 16'h0e4a
`define OTP_IX_OT_LVL_M3 16'h0e4b
`define OTP_IX_OT_TIM_M3 16'h0e4c
`define OTP_IX_OT_SEL_M4 16'h0e4d
`define OTP_IX_OT_LVL_M4 16'h0e4e
`define OTP_IX_OT_TIM_M4 16'h0e4f
`define OTP_IX_TH_SEL_M3 16'h0e50
`define OTP_IX_TH_TIM_M3 16'h0e51
`define OTP_IX_TH_SEL_M4 16'h0e52
`define OTP_IX_TH_TIM_M4 16'h0e53
`define OTP_IX_STATUS 16'h0e60
`define OTP_IX_CTRL 16'h0e61
`define OTP_IX_LAST_CODE 16'h0e62

// reset values
`define OTP_RST_OT_SEL 16'h0000
`define OTP_RST_OT_LVL 16'h0078
`define OTP_RST_OT_TIM 16'h0001
`define OTP_RST_TH_SEL 16'h0001
`define OTP_RST_TH_TIM 16'h0258

// setting ranges
`define OTP_LVL_MIN 16'h000a
`define OTP_LVL_MAX 16'h00fa
`define OTP_THT_MIN 16'h012c
`define OTP_THT_MAX 16'h1770

// field positions
`define OTP_CTRL_FRST 0
`define OTP_CTRL_DEB_EN 1

// thermal threshold in percent of full load
`define OTP_TH_PCT 16'h0096

// fault codes
`define OTP_FC_UV_ACC 8'h0b
`define OTP_FC_UV_DEC 8'h0c
`define OTP_FC_UV_CON 8'h0d
`define OTP_FC_DEB 8'h3e
`define OTP_FC_OT3 8'h80
`define OTP_FC_OT4 8'h81
`define OTP_FC_TH3 8'h86
`define OTP_FC_TH4 8'h87

// timing: time settings count in 0.1 s steps
`define OTP_CLK_KHZ 25000
`define OTP_STEP_MS 100

`endif

/* File: src/otp_pkg.sv */
// types for the protection block
package otp_pkg;

    typedef enum logic [2:0] {
        OTP_OT_OFF = 3'h0,
        OTP_OT_CONT_CONST = 3'h1,
        OTP_OT_STOP_CONST = 3'h2,
        OTP_OT_CONT_RUN = 3'h3,
        OTP_OT_STOP_RUN = 3'h4
    } otp_ot_mode_t;

    typedef enum logic [1:0] {
        OTP_TH_EXT = 2'h0,
        OTP_TH_STD = 2'h1,
        OTP_TH_OFF = 2'h2
    } otp_th_mode_t;

    // gray along idle, timing, warn; timing to trip flips both bits
    typedef enum logic [1:0] {
        OTP_S_IDLE = 2'b00,
        OTP_S_TIME = 2'b01,
        OTP_S_WARN = 2'b11,
        OTP_S_TRIP = 2'b10
    } otp_ot_state_t;

endpackage

/* File: src/otp_prot.sv */
// over-torque and thermal protection for motors 3 and 4
`timescale 1ns/1ps
`include "otp_params.svh"

module otp_prot #(
    parameter int STEP_CYC = `OTP_STEP_MS * `OTP_CLK_KHZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive state
    input wire logic run_active,
    input wire logic const_speed,
    input wire logic undervolt_at_stop,
    input wire logic undervolt_accel,
    input wire logic undervolt_decel,
    input wire logic undervolt_const,
    input wire logic decel_energy_backup,
    // motor 3 measurements
    input wire logic [15:0] cur_drv_m3,
    input wire logic [15:0] cur_mot_m3,
    input wire logic low_speed_m3,
    // motor 4 measurements
    input wire logic [15:0] cur_drv_m4,
    input wire logic [15:0] cur_mot_m4,
    input wire logic low_speed_m4,
    // protection outputs
    output logic overtorque_warn_m3,
    output logic overtorque_warn_m4,
    output logic overtorque_fault_m3,
    output logic overtorque_fault_m4,
    output logic thermal_trip_m3,
    output logic thermal_trip_m4,
    output logic run_inhibit,
    output logic coast_stop,
    // fault record write port
    output logic fault_rec_wr,
    output logic fault_rec_both,
    output logic [7:0] fault_rec_code
);

    // register select: 0..9 settings, 10 status, 11 ctrl, 12 code
    function automatic logic [3:0] otp_dec(input logic [15:0] ix);
        logic [3:0] r;
        r = 4'hf;
        if (ix == `OTP_IX_OT_SEL_M3) begin
            r = 4'h0;
        end else if (ix == `OTP_IX_OT_LVL_M3) begin
            r = 4'h1;
        end else if (ix == `OTP_IX_OT_TIM_M3) begin
            r = 4'h2;
        end else if (ix == `OTP_IX_OT_SEL_M4) begin
            r = 4'h3;
        end else if (ix == `OTP_IX_OT_LVL_M4) begin
            r = 4'h4;
        end else if (ix == `OTP_IX_OT_TIM_M4) begin
            r = 4'h5;
        end else if (ix == `OTP_IX_TH_SEL_M3) begin
            r = 4'h6;
        end else if (ix == `OTP_IX_TH_TIM_M3) begin
            r = 4'h7;
        end else if (ix == `OTP_IX_TH_SEL_M4) begin
            r = 4'h8;
        end else if (ix == `OTP_IX_TH_TIM_M4) begin
            r = 4'h9;
        end else if (ix == `OTP_IX_STATUS) begin
            r = 4'ha;
        end else if (ix == `OTP_IX_CTRL) begin
            r = 4'hb;
        end else if (ix == `OTP_IX_LAST_CODE) begin
            r = 4'hc;
        end
        return r;
    endfunction

    // settings, index 0 is motor 3, 1 is motor 4
    logic [15:0] ot_sel_r [2];
    logic [15:0] ot_lvl_r [2];
    logic [15:0] ot_tim_r [2];
    logic [15:0] th_sel_r [2];
    logic [15:0] th_tim_r [2];
    logic deb_en_r;
    logic frst_r;
    logic [7:0] last_code_r;

    // per-motor state
    otp_pkg::otp_ot_state_t ot_st_r [2];
    logic [15:0] ot_cnt_r [2];
    logic ot_stop_ev_r [2];
    logic [31:0] th_acc_r [2];
    logic th_trip_r [2];
    logic th_ev_r [2];

    logic [15:0] cur_drv [2];
    logic [15:0] cur_mot [2];
    logic low_spd [2];

    logic [31:0] step_cnt_r;
    logic step_r;

    logic [3:0] sel_ix;
    logic wr_acc;
    logic [31:0] rd_nxt;

    assign cur_drv[0] = cur_drv_m3;
    assign cur_drv[1] = cur_drv_m4;
    assign cur_mot[0] = cur_mot_m3;
    assign cur_mot[1] = cur_mot_m4;
    assign low_spd[0] = low_speed_m3;
    assign low_spd[1] = low_speed_m4;

    assign sel_ix = otp_dec(paddr[17:2]);
    assign wr_acc = psel && penable && pwrite && pready;

    // 0.1 s time base shared by both motors
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            step_cnt_r <= 32'h0;
            step_r <= 1'b0;
        end else if (step_cnt_r == 32'(STEP_CYC - 1)) begin
            step_cnt_r <= 32'h0;
            step_r <= 1'b1;
        end else begin
            step_cnt_r <= step_cnt_r + 32'h1;
            step_r <= 1'b0;
        end
    end

    // apb: one setup cycle, answer in the first access cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (sel_ix == 4'hf);
            prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0;
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        case (sel_ix)
            4'h0: rd_nxt[15:0] = ot_sel_r[0];
            4'h1: rd_nxt[15:0] = ot_lvl_r[0];
            4'h2: rd_nxt[15:0] = ot_tim_r[0];
            4'h3: rd_nxt[15:0] = ot_sel_r[1];
            4'h4: rd_nxt[15:0] = ot_lvl_r[1];
            4'h5: rd_nxt[15:0] = ot_tim_r[1];
            4'h6: rd_nxt[15:0] = th_sel_r[0];
            4'h7: rd_nxt[15:0] = th_tim_r[0];
            4'h8: rd_nxt[15:0] = th_sel_r[1];
            4'h9: rd_nxt[15:0] = th_tim_r[1];
            4'ha: rd_nxt[6:0] = {run_inhibit,
                                 thermal_trip_m4, thermal_trip_m3,
                                 overtorque_fault_m4, overtorque_fault_m3,
                                 overtorque_warn_m4, overtorque_warn_m3};
            4'hb: rd_nxt[`OTP_CTRL_DEB_EN] = deb_en_r;
            4'hc: rd_nxt[7:0] = last_code_r;
            default: rd_nxt = 32'h0;
        endcase
    end

    // control: fault reset is a write-one pulse
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            deb_en_r <= 1'b0;
            frst_r <= 1'b0;
        end else begin
            frst_r <= wr_acc && (sel_ix == 4'hb)
                      && pwdata[`OTP_CTRL_FRST];
            if (wr_acc && (sel_ix == 4'hb)) begin
                deb_en_r <= pwdata[`OTP_CTRL_DEB_EN];
            end
        end
    end

    genvar m;
    generate
        for (m = 0; m < 2; m++) begin : g_motor
            localparam logic [3:0] IX0 = 4'(3 * m);
            localparam logic [3:0] IXT = 4'(6 + 2 * m);
            otp_pkg::otp_ot_mode_t mode;
            otp_pkg::otp_th_mode_t tmode;
            logic win;
            logic over;
            logic low_cur;
            logic hot;
            logic [31:0] weight;
            logic [31:0] limit;

            // settings for this motor only
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    ot_sel_r[m] <= `OTP_RST_OT_SEL;
                    ot_lvl_r[m] <= `OTP_RST_OT_LVL;
                    ot_tim_r[m] <= `OTP_RST_OT_TIM;
                    th_sel_r[m] <= `OTP_RST_TH_SEL;
                    th_tim_r[m] <= `OTP_RST_TH_TIM;
                end else if (wr_acc) begin
                    // undefined selections are ignored, not stored
                    if (sel_ix == IX0 && pwdata[15:0] <= 16'h0004) begin
                        ot_sel_r[m] <= pwdata[15:0];
                    end
                    if (sel_ix == IX0 + 4'h1) begin
                        if (pwdata[15:0] < `OTP_LVL_MIN) begin
                            ot_lvl_r[m] <= `OTP_LVL_MIN;
                        end else if (pwdata[15:0] > `OTP_LVL_MAX) begin
                            ot_lvl_r[m] <= `OTP_LVL_MAX;
                        end else begin
                            ot_lvl_r[m] <= pwdata[15:0];
                        end
                    end
                    if (sel_ix == IX0 + 4'h2) begin
                        ot_tim_r[m] <= pwdata[15:0];
                    end
                    if (sel_ix == IXT && pwdata[15:0] <= 16'h0002) begin
                        th_sel_r[m] <= pwdata[15:0];
                    end
                    if (sel_ix == IXT + 4'h1) begin
                        if (pwdata[15:0] < `OTP_THT_MIN) begin
                            th_tim_r[m] <= `OTP_THT_MIN;
                        end else if (pwdata[15:0] > `OTP_THT_MAX) begin
                            th_tim_r[m] <= `OTP_THT_MAX;
                        end else begin
                            th_tim_r[m] <= pwdata[15:0];
                        end
                    end
                end
            end

            assign mode = otp_pkg::otp_ot_mode_t'(ot_sel_r[m][2:0]);
            assign tmode = otp_pkg::otp_th_mode_t'(th_sel_r[m][1:0]);

            // modes 1,2 watch constant speed only; 3,4 all of run
            assign win = run_active && (mode != otp_pkg::OTP_OT_OFF)
                && (const_speed || mode == otp_pkg::OTP_OT_CONT_RUN
                    || mode == otp_pkg::OTP_OT_STOP_RUN);
            assign over = cur_drv[m] > ot_lvl_r[m];
            // 20 x current below level means under 5 percent
            assign low_cur = ({5'h0, cur_drv[m]} * 21'h14)
                             < {5'h0, ot_lvl_r[m]};

            // over-torque detector
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    ot_st_r[m] <= otp_pkg::OTP_S_IDLE;
                    ot_cnt_r[m] <= 16'h0;
                    ot_stop_ev_r[m] <= 1'b0;
                end else begin
                    ot_stop_ev_r[m] <= 1'b0;
                    case (ot_st_r[m])
                        otp_pkg::OTP_S_IDLE: begin
                            ot_cnt_r[m] <= 16'h0;
                            if (win && over) begin
                                ot_st_r[m] <= otp_pkg::OTP_S_TIME;
                            end
                        end
                        otp_pkg::OTP_S_TIME: begin
                            if (!(win && over)) begin
                                ot_st_r[m] <= otp_pkg::OTP_S_IDLE;
                            end else if (ot_cnt_r[m] > ot_tim_r[m]) begin
                                if (mode == otp_pkg::OTP_OT_STOP_CONST
                                    || mode == otp_pkg::OTP_OT_STOP_RUN)
                                begin
                                    ot_st_r[m] <= otp_pkg::OTP_S_TRIP;
                                    ot_stop_ev_r[m] <= 1'b1;
                                end else begin
                                    ot_st_r[m] <= otp_pkg::OTP_S_WARN;
                                end
                            end else if (step_r
                                         && ot_cnt_r[m] != 16'hffff) begin
                                ot_cnt_r[m] <= ot_cnt_r[m] + 16'h1;
                            end
                        end
                        otp_pkg::OTP_S_WARN: begin
                            // warning ignores run state; low current or mode 0 ends it
                            if (low_cur || mode == otp_pkg::OTP_OT_OFF) begin
                                ot_st_r[m] <= otp_pkg::OTP_S_IDLE;
                            end
                        end
                        otp_pkg::OTP_S_TRIP: begin
                            if (frst_r) begin
                                ot_st_r[m] <= otp_pkg::OTP_S_IDLE;
                            end
                        end
                        default: ot_st_r[m] <= otp_pkg::OTP_S_IDLE;
                    endcase
                end
            end

            // thermal relay; weight grows with current
            assign hot = cur_mot[m] > `OTP_TH_PCT;
            assign weight = (tmode == otp_pkg::OTP_TH_STD && low_spd[m])
                ? {15'h0, cur_mot[m], 1'b0}
                : {16'h0, cur_mot[m]};
            assign limit = {16'h0, th_tim_r[m]}
                           * {16'h0, `OTP_TH_PCT};

            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    th_acc_r[m] <= 32'h0;
                    th_trip_r[m] <= 1'b0;
                    th_ev_r[m] <= 1'b0;
                end else begin
                    th_ev_r[m] <= 1'b0;
                    // a trip landing with a fault reset must not be lost
                    if (tmode != otp_pkg::OTP_TH_OFF && !th_trip_r[m]
                        && th_acc_r[m] > limit) begin
                        th_trip_r[m] <= 1'b1;
                        th_ev_r[m] <= 1'b1;
                    end else if (frst_r) begin
                        th_acc_r[m] <= 32'h0;
                        th_trip_r[m] <= 1'b0;
                    end else if (tmode == otp_pkg::OTP_TH_OFF) begin
                        th_acc_r[m] <= 32'h0;
                    end else if (!th_trip_r[m] && step_r && hot) begin
                        // accumulation holds while below threshold
                        th_acc_r[m] <= th_acc_r[m] + weight;
                    end
                end
            end
        end
    endgenerate

    // protection outputs, all registered
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            overtorque_warn_m3 <= 1'b0;
            overtorque_warn_m4 <= 1'b0;
            overtorque_fault_m3 <= 1'b0;
            overtorque_fault_m4 <= 1'b0;
            thermal_trip_m3 <= 1'b0;
            thermal_trip_m4 <= 1'b0;
            run_inhibit <= 1'b0;
            coast_stop <= 1'b0;
        end else begin
            overtorque_warn_m3 <= ot_st_r[0] == otp_pkg::OTP_S_WARN;
            overtorque_warn_m4 <= ot_st_r[1] == otp_pkg::OTP_S_WARN;
            overtorque_fault_m3 <= ot_st_r[0] == otp_pkg::OTP_S_TRIP;
            overtorque_fault_m4 <= ot_st_r[1] == otp_pkg::OTP_S_TRIP;
            thermal_trip_m3 <= th_trip_r[0];
            thermal_trip_m4 <= th_trip_r[1];
            run_inhibit <= ot_st_r[0] == otp_pkg::OTP_S_TRIP
                           || ot_st_r[1] == otp_pkg::OTP_S_TRIP
                           || th_trip_r[0] || th_trip_r[1];
            coast_stop <= th_trip_r[0] || th_trip_r[1];
        end
    end

    // fault recorder: one stopping fault per cycle, fixed priority
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fault_rec_wr <= 1'b0;
            fault_rec_both <= 1'b0;
            fault_rec_code <= 8'h0;
            last_code_r <= 8'h0;
        end else begin
            fault_rec_wr <= 1'b1;
            fault_rec_both <= 1'b0;
            if (deb_en_r && decel_energy_backup) begin
                fault_rec_code <= `OTP_FC_DEB;
                fault_rec_both <= 1'b1;
                last_code_r <= `OTP_FC_DEB;
            end else if (th_ev_r[0]) begin
                fault_rec_code <= `OTP_FC_TH3;
                last_code_r <= `OTP_FC_TH3;
            end else if (th_ev_r[1]) begin
                fault_rec_code <= `OTP_FC_TH4;
                last_code_r <= `OTP_FC_TH4;
            end else if (ot_stop_ev_r[0]) begin
                fault_rec_code <= `OTP_FC_OT3;
                last_code_r <= `OTP_FC_OT3;
            end else if (ot_stop_ev_r[1]) begin
                fault_rec_code <= `OTP_FC_OT4;
                last_code_r <= `OTP_FC_OT4;
            end else if (undervolt_accel) begin
                fault_rec_code <= `OTP_FC_UV_ACC;
                last_code_r <= `OTP_FC_UV_ACC;
            end else if (undervolt_decel) begin
                fault_rec_code <= `OTP_FC_UV_DEC;
                last_code_r <= `OTP_FC_UV_DEC;
            end else if (undervolt_const) begin
                fault_rec_code <= `OTP_FC_UV_CON;
                last_code_r <= `OTP_FC_UV_CON;
            end else begin
                // undervolt at stop falls here: never recorded
                fault_rec_wr <= 1'b0;
            end
        end
    end

    // undervolt_at_stop is accepted only so the bench can drive it
    logic unused_uvs;
    assign unused_uvs = undervolt_at_stop;

endmodule

/* File: tb/otp_prot_assertions.sv */
// port checker for the motor 3/4 protection block
`timescale 1ns/1ps
module otp_prot_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // drive and protection
    input wire logic run_active,
    input wire logic [15:0] cur_mot_m3,
    input wire logic overtorque_fault_m3,
    input wire logic thermal_trip_m3,
    input wire logic run_inhibit,
    input wire logic coast_stop,
    input wire logic fault_rec_wr,
    input wire logic fault_rec_both,
    input wire logic [7:0] fault_rec_code
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    bus_answer_a: assert property (setup_s ##1 access_s |-> pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    backup_both_a: assert property (
        fault_rec_both |-> fault_rec_wr && fault_rec_code == 8'h3e)
        else $error("both sets without backup code");
    ot_record_a: assert property (
        fault_rec_wr && fault_rec_code == 8'h80 |-> overtorque_fault_m3)
        else $error("over-torque code without stop");
    stop_inhibit_a: assert property (
        overtorque_fault_m3 |-> run_inhibit)
        else $error("stop latch without inhibit");
    thermal_coast_a: assert property (
        thermal_trip_m3 |-> coast_stop && run_inhibit)
        else $error("thermal trip without coast");
    // a stop needs the drive running when the time ran out
    ot_needs_run_a: assert property (
        $rose(overtorque_fault_m3) |-> $past(run_active, 2))
        else $error("over-torque while stopped");
    thermal_above_a: assert property ($rose(thermal_trip_m3) |->
        $past(cur_mot_m3, 2) > 16'h0096 || $past(cur_mot_m3, 3) > 16'h0096)
        else $error("thermal trip below threshold");
    no_stop_uv_a: assert property (
        fault_rec_wr |-> fault_rec_code != 8'h0e)
        else $error("undervolt at stop recorded");
endmodule
bind otp_prot otp_prot_assertions chk (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .run_active(run_active), .cur_mot_m3(cur_mot_m3),
    .overtorque_fault_m3(overtorque_fault_m3),
    .thermal_trip_m3(thermal_trip_m3), .run_inhibit(run_inhibit),
    .coast_stop(coast_stop), .fault_rec_wr(fault_rec_wr),
    .fault_rec_both(fault_rec_both), .fault_rec_code(fault_rec_code));

/* File: tb/otp_prot_tb_top.sv */
// testbench for the motor 3/4 protection block
`timescale 1ns/1ps
`include "otp_params.svh"
module otp_prot_tb_top;
    logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, st, last_both, run_active = 0;
    logic const_speed = 0, low_speed_m3 = 0, low_speed_m4 = 0;
    logic undervolt_at_stop = 0, undervolt_accel = 0, undervolt_decel = 0;
    logic undervolt_const = 0, decel_energy_backup = 0;
    logic [15:0] cur_drv_m3 = 0, cur_mot_m3 = 0, cur_drv_m4 = 0;
    logic [15:0] cur_mot_m4 = 0;
    logic overtorque_warn_m3, overtorque_warn_m4, overtorque_fault_m3;
    logic overtorque_fault_m4, thermal_trip_m3, thermal_trip_m4;
    logic run_inhibit, coast_stop, fault_rec_wr, fault_rec_both;
    logic [7:0] fault_rec_code, last_code;
    logic [15:0] rv [10] = '{16'h0, 16'h78, `OTP_RST_OT_TIM, 16'h0, 16'h78,
        `OTP_RST_OT_TIM, 16'h1, 16'h258, 16'h1, 16'h258};
    int ts [7] = '{0, 0, 1, 1, 0, 0, 2};
    int tc [7] = '{300, 300, 300, 300, 600, 150, 300};
    int tl [7] = '{1, 0, 1, 0, 0, 0, 1};
    int mismatches = 0, n_checks = 0, n_rec = 0, t0, k, e;

    always #20 mclk = ~mclk;
    // short time step keeps the thermal runs to a few thousand cycles
    otp_prot #(.STEP_CYC(10)) dut (.*);
    always @(posedge mclk) begin
        if (fault_rec_wr === 1'b1) begin
            n_rec++;
            last_code = fault_rec_code;
            last_both = fault_rec_both;
        end
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [15:0] ix, input logic [31:0] wd);
        int j;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        j = 0;
        do begin
            @(posedge mclk);
            j++;
        end while (pready !== 1'b1 && j < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: bus hang", $time);
            end_of_test;
        end
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(0, 16'h0e4a + i, 0);
            chk(rd, {16'h0, rv[i]});
        end
        apb(0, 16'h0e70, 0);
        chk(err, 1);
        apb(1, 16'h0e51, 16'h0064);
        apb(0, 16'h0e51, 0);
        chk(rd, 32'h012c);
        $display("register test done");
        apb(1, 16'h0e4c, 0);
        for (int c = 0; c < 2; c++) begin
            for (int m = 0; m < 5; m++) begin
                t0 = n_rec;
                st = m == 4 || (c == 1 && m == 2);
                apb(1, 16'h0e4a, m);
                const_speed <= c;
                run_active <= 1'b1;
                cur_drv_m3 <= 200;
                repeat (60) @(posedge mclk);
                chk(overtorque_warn_m3, m == 3 || c == 1 && m == 1);
                chk(overtorque_fault_m3, st);
                chk(n_rec - t0, st);
                if (st)
                    chk(last_code, 8'h80);
                cur_drv_m3 <= 0;
                run_active <= 1'b0;
                repeat (5) @(posedge mclk);
                chk(run_inhibit, st);
                apb(1, 16'h0e61, 1);
            end
        end
        apb(1, 16'h0e4a, 5);
        apb(0, 16'h0e4a, 0);
        chk(rd, 4);
        apb(1, 16'h0e4c, 3);
        run_active <= 1'b1;
        cur_drv_m3 <= 120;
        repeat (60) @(posedge mclk);
        chk(overtorque_fault_m3, 0);
        cur_drv_m3 <= 200;
        repeat (30) @(posedge mclk);
        chk(overtorque_fault_m3, 0);
        for (k = 0; k < 40 && overtorque_fault_m3 !== 1'b1; k++)
            @(posedge mclk);
        chk(overtorque_fault_m3, 1);
        chk(overtorque_fault_m4, 0);
        apb(0, 16'h0e60, 0);
        chk(rd, 32'h44);
        cur_drv_m3 <= 0;
        apb(1, 16'h0e61, 1);
        $display("over-torque stop test done");
        apb(1, 16'h0e4d, 3);
        apb(1, 16'h0e4e, 100);
        apb(1, 16'h0e4f, 0);
        cur_drv_m4 <= 150;
        for (k = 0; k < 60 && overtorque_warn_m4 !== 1'b1; k++)
            @(posedge mclk);
        chk(overtorque_warn_m4, 1);
        chk(overtorque_warn_m3, 0);
        cur_drv_m4 <= 5;
        repeat (20) @(posedge mclk);
        chk(overtorque_warn_m4, 1);
        cur_drv_m4 <= 4;
        repeat (5) @(posedge mclk);
        chk(overtorque_warn_m4, 0);
        $display("warning test done");
        for (int i = 0; i < 7; i++) begin
            apb(1, 16'h0e50, ts[i]);
            cur_mot_m3 <= tc[i];
            low_speed_m3 <= tl[i];
            e = (ts[i] == 1 && tl[i] == 1) ? 2 : 1;
            e = (ts[i] == 2 || tc[i] <= 150) ? 0 : 45000 / (tc[i] * e) + 1;
            for (k = 0; k < 2000 && thermal_trip_m3 !== 1'b1; k++)
                @(posedge mclk);
            cur_mot_m3 <= 0;
            chk(thermal_trip_m3, e != 0);
            chk(thermal_trip_m4, 0);
            if (e != 0) begin
                chk(k >= e * 10 - 12 && k <= e * 10 + 12, 1);
                chk(coast_stop, 1);
            end
            repeat (3) @(posedge mclk);
            if (e != 0)
                chk(last_code, 8'h86);
            apb(1, 16'h0e61, 1);
        end
        $display("thermal test done");
        t0 = n_rec;
        undervolt_at_stop <= 1'b1;
        decel_energy_backup <= 1'b1;
        repeat (5) @(posedge mclk);
        undervolt_at_stop <= 1'b0;
        decel_energy_backup <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(n_rec - t0, 0);
        for (int i = 0; i < 3; i++) begin
            {undervolt_accel, undervolt_decel, undervolt_const} <= 3'h4 >> i;
            @(posedge mclk);
            {undervolt_accel, undervolt_decel, undervolt_const} <= 3'h0;
            repeat (3) @(posedge mclk);
            chk(last_code, 8'h0b + i);
        end
        apb(1, 16'h0e61, 2);
        decel_energy_backup <= 1'b1;
        @(posedge mclk);
        decel_energy_backup <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(last_code, 8'h3e);
        chk(last_both, 1);
        apb(0, 16'h0e62, 0);
        chk(rd, 32'h3e);
        $display("recorder test done");
        end_of_test;
    end
endmodule
